/* File: gdps_top.sv */
/*
  Protection and sequencing core of a high-side gate driver.
  Assumes asynchronous pin inputs (control, comparators); each is synchronised.
*/
`timescale 1ns/10ps
module gdps_top
  import gdps_pkg::*;
#(
  parameter int unsigned SLEEP_CYC_P = SLEEP_CYC,
  parameter int unsigned HOLD_CYC_P = HOLD_CYC,
  parameter int unsigned BLANK_CYC_P = BLANK_CYC
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic ctrl_in_i,
  input wire logic vds_over_i,
  input wire logic supply_low_detect_i,
  output logic gate_on_o,
  output logic boot_reg_en_o,
  output logic fault_diag_pin_o,
  output logic asleep_o
);
  // Synchroniser stages
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic in_s;
  logic vds_s;
  logic uv_s;
  // Previous synchronised levels for edge detection
  logic in_d_r;
  logic uv_d_r;
  // State and timers
  gdps_state_t state_r;
  gdps_state_t state_nxt;
  logic [TMR_W-1:0] tmr_r;
  logic [TMR_W-1:0] idle_r;
  logic [TMR_W-1:0] blank_r;
  logic blank_done;
  logic fault_r;
  logic sleep_go;
  logic in_rise;
  logic uv_rise;
  // Event counter links
  gdps_evt_if uv_evt();
  gdps_evt_if pw_evt();

  // Two-flop synchronisers for the three pins
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
    end else begin
      sync1_r <= {supply_low_detect_i, vds_over_i, ctrl_in_i};
      sync2_r <= sync1_r;
    end
  end
  assign in_s = sync2_r[0];
  assign vds_s = sync2_r[1];
  assign uv_s = sync2_r[2];

  // Edge history
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      in_d_r <= 1'b0;
      uv_d_r <= 1'b0;
    end else begin
      in_d_r <= in_s;
      uv_d_r <= uv_s;
    end
  end
  assign in_rise = in_s && !in_d_r;
  assign uv_rise = uv_s && !uv_d_r;

  // Inactive-input timer
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      idle_r <= '0;
    end else if (in_s || state_r == GDPS_SLEEP) begin
      idle_r <= '0;
    end else if (idle_r != SLEEP_CYC_P[TMR_W-1:0]) begin
      idle_r <= idle_r + 1'b1;
    end
  end
  assign sleep_go = (idle_r == SLEEP_CYC_P[TMR_W-1:0]) && (state_r != GDPS_SLEEP);

  // Next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      GDPS_SLEEP: begin
        if (in_s) begin
          state_nxt = GDPS_WAKE;
        end
      end
      GDPS_WAKE: begin
        if (!in_s) begin
          state_nxt = GDPS_SLEEP;
        end else if (tmr_r == WAKE_CYC[TMR_W-1:0] - 1'b1) begin
          state_nxt = GDPS_HOLD;
        end
      end
      GDPS_HOLD: begin
        if (sleep_go) begin
          state_nxt = GDPS_SLEEP;
        end else if (tmr_r == HOLD_CYC_P[TMR_W-1:0] - 1'b1) begin
          state_nxt = GDPS_RUN;
        end
      end
      GDPS_RUN: begin
        if (sleep_go) begin
          state_nxt = GDPS_SLEEP;
        end
      end
      default: begin
        state_nxt = GDPS_SLEEP;
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= GDPS_SLEEP;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Phase timer, restarts on each state change
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tmr_r <= '0;
    end else if (state_nxt != state_r) begin
      tmr_r <= '0;
    end else if (state_r == GDPS_WAKE || state_r == GDPS_HOLD) begin
      tmr_r <= tmr_r + 1'b1;
    end
  end

  // Blanking timer, runs while gate is commanded on and supply is not low
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      blank_r <= '0;
    end else if (!gate_on_o || uv_s) begin
      blank_r <= '0;
    end else if (!blank_done) begin
      blank_r <= blank_r + 1'b1;
    end
  end
  assign blank_done = (blank_r == BLANK_CYC_P[TMR_W-1:0]);

  // Counter controls
  always_comb begin
    uv_evt.inc = uv_rise && (state_r == GDPS_RUN);
    uv_evt.clr = sleep_go;
    pw_evt.inc = in_rise && (state_r == GDPS_RUN);
    pw_evt.clr = !vds_s || sleep_go;
  end

  gdps_evt_cnt u_uv_cnt (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .evt(uv_evt)
  );

  gdps_evt_cnt u_pw_cnt (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .evt(pw_evt)
  );

  // Fault latch
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fault_r <= 1'b0;
    end else if (gate_on_o && blank_done && vds_s) begin
      fault_r <= 1'b1;
    end else if (uv_evt.hit || pw_evt.hit) begin
      fault_r <= 1'b1;
    end else if (sleep_go || state_r == GDPS_SLEEP) begin
      // cleared on sleep
      // Sleep clears the counters one edge late, so keep clearing while asleep
      fault_r <= 1'b0;
    end
  end

  // Outputs
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gate_on_o <= 1'b0;
      fault_diag_pin_o <= 1'b0;
    end else begin
      gate_on_o <= (state_nxt == GDPS_RUN) && in_s && !fault_r && !uv_s && !uv_evt.hit && !pw_evt.hit
                   && !(gate_on_o && blank_done && vds_s);
      fault_diag_pin_o <= (state_nxt == GDPS_RUN) && in_s && !fault_r;
    end
  end

  // Regulator and sleep indication
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      boot_reg_en_o <= 1'b0;
      asleep_o <= 1'b1;
    end else begin
      boot_reg_en_o <= (state_nxt == GDPS_HOLD) || (state_nxt == GDPS_RUN);
      asleep_o <= (state_nxt == GDPS_SLEEP) || (state_nxt == GDPS_WAKE);
    end
  end
endmodule // gdps_top

/* File: gdps_pkg.sv */
/*
  Constants and state type of the gate driver protection sequencer.
  Assumes a 200 MHz system clock; times are in nanoseconds, microseconds or milliseconds.
*/
package gdps_pkg;
  // Clock period in nanoseconds
  localparam int unsigned CLK_PERIOD_NS = 5;
  // Blanking time, microseconds (typical within 15..35)
  localparam int unsigned BLANK_TIME_US = 22;
  localparam int unsigned BLANK_CYC = (BLANK_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Sleep entry time, milliseconds (typical within 7..30)
  localparam int unsigned SLEEP_TIME_MS = 15;
  localparam int unsigned SLEEP_CYC = (SLEEP_TIME_MS * 1000000) / CLK_PERIOD_NS;
  // Minimum wake pulse, nanoseconds
  localparam int unsigned WAKE_TIME_NS = 500;
  localparam int unsigned WAKE_CYC = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Power-up hold, microseconds (typical within 40..200)
  localparam int unsigned HOLD_TIME_US = 100;
  localparam int unsigned HOLD_CYC = (HOLD_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Event count that latches the device off
  localparam logic [2:0] LATCH_COUNT = 3'h4;
  // Timer width, enough for the longest delay
  localparam int unsigned TMR_W = 24;
  // Operating states
  typedef enum logic [1:0] {
    GDPS_SLEEP,
    GDPS_WAKE,
    GDPS_HOLD,
    GDPS_RUN
  } gdps_state_t;
endpackage

/* File: gdps_evt_if.sv */
/*
  Interface between the sequencer and its event counter.
  Assumes one clock domain shared by both ends.
*/
`timescale 1ns/10ps
interface gdps_evt_if;
  logic inc; // Count one event
  logic clr; // Clear the count
  logic hit; // Count has reached the latch value
  modport ctrl (output inc, output clr, input hit);
  modport cnt (input inc, input clr, output hit);
endinterface

/* File: gdps_evt_cnt.sv */
/*
  Saturating event counter that flags the latch count.
  Assumes synchronous inc/clr from the sequencer on the same clock.
*/
`timescale 1ns/10ps
module gdps_evt_cnt
  import gdps_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  gdps_evt_if.cnt evt
);
  // Event count
  logic [2:0] count_r;

  // Count up to the latch value; increment wins over clear
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_r <= 3'h0;
    end else if (evt.inc) begin
      if (count_r != LATCH_COUNT) begin
        count_r <= count_r + 3'h1;
      end
    end else if (evt.clr) begin
      count_r <= 3'h0;
    end
  end

  assign evt.hit = (count_r == LATCH_COUNT);
endmodule // gdps_evt_cnt

/* File: gdps_host_model.sv */
/*
  Host model: drives the control pin level by level.
  Assumes the bench samples the diagnostic pin itself.
*/
`timescale 1ns/10ps
module gdps_host_model (
  input wire logic clk_i,
  input wire logic diag_i,
  output logic ctrl_o
);
  initial ctrl_o = 1'b0;
  task automatic drive(input logic lvl, input int n);
    @(posedge clk_i);
    #1 ctrl_o = lvl;
    repeat (n - 1) @(posedge clk_i);
    #1;
  endtask
endmodule // gdps_host_model

/* File: gdps_top_checker.sv */
/*
  Checker for the sequencer's pin behaviour.
  Assumes it is bound to gdps_top, one clock domain.
*/
`timescale 1ns/10ps
module gdps_top_checker
  import gdps_pkg::*;
#(
  parameter int unsigned SLEEP_CYC_P = 1,
  parameter int unsigned HOLD_CYC_P = 1,
  parameter int unsigned BLANK_CYC_P = 1
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic ctrl_in_i,
  input wire logic vds_over_i,
  input wire logic supply_low_detect_i,
  input wire logic gate_on_o,
  input wire logic boot_reg_en_o,
  input wire logic fault_diag_pin_o,
  input wire logic asleep_o
);
  // Run lengths of control high/low, regulator on, gate on
  int hi_r, lo_r, up_r, on_r;
  always_ff @(posedge sys_clk_i) hi_r <= !reset_n_i ? 0 : (ctrl_in_i ? hi_r + 1 : 0);
  always_ff @(posedge sys_clk_i) lo_r <= !reset_n_i ? 0 : (!ctrl_in_i ? lo_r + 1 : 0);
  always_ff @(posedge sys_clk_i) up_r <= !reset_n_i ? 0 : (boot_reg_en_o ? up_r + 1 : 0);
  always_ff @(posedge sys_clk_i) on_r <= !reset_n_i ? 0 : (gate_on_o ? on_r + 1 : 0);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_boot_sleep; asleep_o |-> !boot_reg_en_o; endproperty
  a_boot_sleep: assert property (p_boot_sleep) else $error("regulator on in sleep");
  property p_wake; $fell(asleep_o) |-> hi_r >= WAKE_CYC; endproperty
  a_wake: assert property (p_wake) else $error("wake on short pulse");
  property p_boot; $fell(asleep_o) |-> ##[0:1] boot_reg_en_o; endproperty
  a_boot: assert property (p_boot) else $error("regulator not on at wake");
  property p_hold; boot_reg_en_o && up_r < HOLD_CYC_P - 2 |-> !gate_on_o; endproperty
  a_hold: assert property (p_hold) else $error("gate on during hold");
  property p_uv; supply_low_detect_i [*4] |-> !gate_on_o; endproperty
  a_uv: assert property (p_uv) else $error("gate on in supply low");
  property p_blank;
    $rose(gate_on_o) && up_r < HOLD_CYC_P + 9 ##1 (ctrl_in_i && !supply_low_detect_i) [*8] |-> gate_on_o;
  endproperty
  a_blank: assert property (p_blank) else $error("gate cut in blanking");
  property p_oc; on_r > BLANK_CYC_P + 2 && vds_over_i |-> ##[1:5] !gate_on_o; endproperty
  a_oc: assert property (p_oc) else $error("over-current ignored");
  property p_sleep; lo_r > SLEEP_CYC_P + 5 |-> asleep_o; endproperty
  a_sleep: assert property (p_sleep) else $error("no sleep entry");
  c_wake: cover property ($fell(asleep_o));
  c_sleep: cover property ($rose(asleep_o));
  c_fault: cover property ($fell(fault_diag_pin_o) && ctrl_in_i);
endmodule // gdps_top_checker
bind gdps_top gdps_top_checker #(.SLEEP_CYC_P(SLEEP_CYC_P), .HOLD_CYC_P(HOLD_CYC_P),
  .BLANK_CYC_P(BLANK_CYC_P)) gdps_top_checker_inst (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
  .ctrl_in_i(ctrl_in_i), .vds_over_i(vds_over_i), .supply_low_detect_i(supply_low_detect_i),
  .gate_on_o(gate_on_o), .boot_reg_en_o(boot_reg_en_o), .fault_diag_pin_o(fault_diag_pin_o),
  .asleep_o(asleep_o));

/* File: gdps_tb_top.sv */
/*
  Bench: host model drives control, bench drives comparators.
  Assumes short counts: sleep 200, hold 50, blanking 20.
*/
`timescale 1ns/10ps
module gdps_tb_top;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic vds = 1'b0;
  logic uv = 1'b0;
  logic ctrl, gate, boot, diag, asleep;
  int n_fail = 0;
  int check_count = 0;
  always #2.5 sys_clk = ~sys_clk;
  gdps_host_model gdps_host_model_inst (.clk_i(sys_clk), .diag_i(diag), .ctrl_o(ctrl));
  gdps_top #(.SLEEP_CYC_P(200), .HOLD_CYC_P(50), .BLANK_CYC_P(20)) gdps_top_inst (.sys_clk_i(sys_clk),
    .reset_n_i(reset_n), .ctrl_in_i(ctrl), .vds_over_i(vds), .supply_low_detect_i(uv),
    .gate_on_o(gate), .boot_reg_en_o(boot), .fault_diag_pin_o(diag), .asleep_o(asleep));
  // Compare one pin level
  task automatic chk(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic hd(input logic lvl, input int n);
    gdps_host_model_inst.drive(lvl, n);
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    report_and_stop;
  end
  initial begin
    void'($urandom(32'h69b9));
    cy(10);
    reset_n = 1'b1;
    chk("boot", 1'b0, boot);
    hd(1'b1, 50);
    hd(1'b0, 5);
    chk("asleep", 1'b1, asleep);
    hd(1'b1, 110);
    chk("boot", 1'b1, boot);
    chk("gate", 1'b0, gate);
    vds = 1'b1;
    hd(1'b1, 50);
    chk("gate", 1'b1, gate);
    hd(1'b1, 30);
    chk("gate", 1'b0, gate);
    chk("diag", 1'b0, diag);
    hd(1'b0, 220);
    vds = 1'b0;
    chk("asleep", 1'b1, asleep);
    hd(1'b1, 180);
    chk("diag", 1'b1, diag);
    for (int i = 1; i <= 4; i++) begin
      uv = 1'b1;
      cy(5);
      chk("gate", 1'b0, gate);
      uv = 1'b0;
      cy(25 + $urandom % 10);
      chk("diag", i < 4, diag);
    end
    hd(1'b0, 220);
    hd(1'b1, 180);
    uv = 1'b1;
    cy(5);
    uv = 1'b0;
    cy(30);
    chk("diag", 1'b1, diag);
    hd(1'b0, 5);
    vds = 1'b1;
    for (int k = 1; k <= 7; k++) begin
      hd(1'b0, 4);
      if (k == 4) begin
        vds = 1'b0;
        cy(4);
        vds = 1'b1;
      end
      hd(1'b1, 6 + $urandom % 3);
      chk("gate", k < 7, gate);
    end
    chk("diag", 1'b0, diag);
    report_and_stop;
  end
endmodule // gdps_tb_top
